// [logic/cgsr_regs.sv]
`default_nettype none
// Function
// - live bit 0 shows calibration running
// - live bit 1 shows crystal pin signal loss
// - live bit 2 shows phase detector reference missing
// - live bit 3 shows loop out of lock
// - live bit 5 shows bus timeout; bit 4 unused
// - four live per-input loss bits, feedback on bit 3
// - per-input loss bits follow input, never latch
// - sticky status flags, cleared by writing zero
// - sticky per-input flags, zero clears each one
// - status mask bit one blocks that flag
// - masked flags still latch normally
// - per-input mask bit one blocks that flag
// - soft reset write one resets logic, keeps config
// - soft reset bit clears itself
// - soft reset realigns all output clocks
// - step-up strobe rising edge steps frequency up
// - step-down strobe rising edge steps frequency down
// - low power while power-down bit is one
// - hard reset acts like power-up, reloads config
// - sync strobe realigns all output dividers
// - reference select from pins or register field
module cgsr_regs (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire cgsr_pkg::cgsr_reg_req_t reg_req,
  output logic [cgsr_pkg::DATA_W-1:0]  reg_rdata,
  output logic                         reg_rvalid,
  input  wire cgsr_pkg::cgsr_status_t  status_pins,
  input  wire logic [cgsr_pkg::SEL_W-1:0] sel_pins,
  output var cgsr_pkg::cgsr_ctrl_t     ctrl,
  output logic                         intr_n
);
  import cgsr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] sticky_status;
    logic [LOSS_N-1:0] sticky_loss;
    logic [DATA_W-1:0] status_masks;
    logic [LOSS_N-1:0] loss_masks;
    logic [1:0]        step_strobes;
    logic              sync_strobe;
    logic              low_power;
    logic              hard_bit;
    logic              sel_src;
    logic [SEL_W-1:0]  sel_field;
    cgsr_seq_t         seq;
    cgsr_ctrl_t        ctrl;
    logic              intr_n;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } cgsr_state_t;

  cgsr_state_t  st_reg;
  cgsr_state_t  st_next;
  cgsr_status_t live;
  logic [SEL_W-1:0] pins_sel;

  // every alarm and select pin crosses from outside on two flops
  cgsr_sync #(
    .W ($bits(cgsr_status_t) + SEL_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d_async ({status_pins, sel_pins}),
    .q       ({live, pins_sel})
  );

  // address decode for the write path; the read path decodes with its own case
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // live status byte, unused bits read zero
  function automatic logic [DATA_W-1:0] live_byte(input cgsr_status_t s);
    logic [DATA_W-1:0] r;
    r              = '0;
    r[BIT_CAL]     = s.calibration_in_progress;
    r[BIT_XTAL]    = s.crystal_input_signal_loss;
    r[BIT_REFMISS] = s.phase_detector_reference_missing;
    r[BIT_UNLOCK]  = s.pll_unlocked;
    r[BIT_TIMEOUT] = s.serial_bus_timeout;
    live_byte      = r;
  endfunction

  logic              wr_sticky_s;
  logic              wr_sticky_l;
  logic              wr_ctrl;
  logic              soft_go;
  logic              hold_cfg;
  logic [DATA_W-1:0] live_now;
  logic [DATA_W-1:0] loss_byte;

  // next state of the whole bank
  always_comb begin
    st_next     = st_reg;
    live_now    = live_byte(live);
    loss_byte   = {{(DATA_W-LOSS_N){1'b0}}, live.per_input_signal_loss};
    wr_sticky_s = reg_req.wr && hit(reg_req.addr, OFS_STICKY_STATUS);
    wr_sticky_l = reg_req.wr && hit(reg_req.addr, OFS_STICKY_LOSS);
    wr_ctrl     = reg_req.wr && hit(reg_req.addr, OFS_SYNC_PDN_HARD);
    // a soft reset is ignored while one is running or a hard reset holds
    soft_go     = reg_req.wr && hit(reg_req.addr, OFS_SOFT_RESET)
                  && reg_req.wdata[BIT_SOFT_RST] && (st_reg.seq == ST_RUN);
    hold_cfg    = (st_reg.seq == ST_HARD);

    // hard reset bit stays until software writes it back to zero
    if (wr_ctrl) begin
      st_next.low_power = reg_req.wdata[BIT_LOW_POWER];
      st_next.hard_bit  = reg_req.wdata[BIT_HARD_RST];
    end

    // reset sequencer
    case (st_reg.seq)
      ST_RUN: begin
        if (st_next.hard_bit) begin
          st_next.seq = ST_HARD;
        end else if (soft_go) begin
          st_next.seq = ST_SOFT;
        end
      end
      ST_SOFT: begin
        st_next.seq = st_next.hard_bit ? ST_HARD : ST_RUN;
      end
      ST_HARD: begin
        if (!st_next.hard_bit) begin
          st_next.seq = ST_RUN;
        end
      end
      default: begin
        st_next.seq = ST_RUN;
      end
    endcase

    // sticky flags: software clears with zeros, a live alarm in the same cycle wins
    if (wr_sticky_s) begin
      st_next.sticky_status = st_reg.sticky_status & reg_req.wdata;
    end
    if (wr_sticky_l) begin
      st_next.sticky_loss = st_reg.sticky_loss & reg_req.wdata[LOSS_N-1:0];
    end
    if (soft_go || hold_cfg) begin
      st_next.sticky_status = '0;
      st_next.sticky_loss   = '0;
    end
    // flags latch whatever the masks say
    st_next.sticky_status = (st_next.sticky_status | live_now) & STATUS_USED;
    st_next.sticky_loss   = st_next.sticky_loss | live.per_input_signal_loss;

    // plain configuration, held at reset values during hard reset
    if (reg_req.wr && hit(reg_req.addr, OFS_STATUS_MASKS)) begin
      st_next.status_masks = reg_req.wdata & STATUS_USED;
    end
    if (reg_req.wr && hit(reg_req.addr, OFS_LOSS_MASKS)) begin
      st_next.loss_masks = reg_req.wdata[LOSS_N-1:0];
    end
    if (reg_req.wr && hit(reg_req.addr, OFS_REF_SELECT)) begin
      st_next.sel_src   = reg_req.wdata[BIT_SEL_SRC];
      st_next.sel_field = reg_req.wdata[SEL_LSB +: SEL_W];
    end
    if (hold_cfg) begin
      st_next.status_masks = RST_STATUS_MASKS;
      st_next.loss_masks   = RST_LOSS_MASKS;
      st_next.sel_src      = 1'b0;
      st_next.sel_field    = RST_REF_SELECT;
    end

    // self-clearing strobes live for one cycle after the write
    st_next.step_strobes = '0;
    st_next.sync_strobe  = 1'b0;
    if (reg_req.wr && hit(reg_req.addr, OFS_FREQ_STEP)) begin
      st_next.step_strobes = reg_req.wdata[BIT_STEP_DOWN:BIT_STEP_UP];
    end
    if (wr_ctrl) begin
      st_next.sync_strobe = reg_req.wdata[BIT_SYNC];
    end

    // controls towards the clock path, all registered
    st_next.ctrl.soft_reset          = (st_next.seq == ST_SOFT);
    // soft reset also realigns the outputs, same as an explicit sync
    st_next.ctrl.divider_sync        = st_next.sync_strobe | st_next.ctrl.soft_reset;
    // only a zero-to-one edge steps, so a held one gives one step
    st_next.ctrl.frequency_step_up   = st_next.step_strobes[BIT_STEP_UP]
                                       & ~st_reg.step_strobes[BIT_STEP_UP];
    st_next.ctrl.frequency_step_down = st_next.step_strobes[BIT_STEP_DOWN]
                                       & ~st_reg.step_strobes[BIT_STEP_DOWN];
    st_next.ctrl.low_power_request   = st_next.low_power;
    st_next.ctrl.hard_reset          = st_next.hard_bit;
    st_next.ctrl.nvm_reload          = st_next.hard_bit & ~st_reg.hard_bit;
    // value 3 of the field picks the crystal pair
    st_next.ctrl.ref_select          = st_reg.sel_src ? st_reg.sel_field : pins_sel;

    // interrupt pin low while any unmasked sticky flag stands
    st_next.intr_n = ~(|(st_next.sticky_status & ~st_next.status_masks)
                       | |(st_next.sticky_loss & ~st_next.loss_masks));

    // read port answers one cycle after the request, unmapped reads zero
    st_next.rvalid = reg_req.rd;
    st_next.rdata  = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_LIVE_STATUS:   st_next.rdata = live_now;
        OFS_INPUT_LOSS:    st_next.rdata = loss_byte;
        OFS_STICKY_STATUS: st_next.rdata = st_reg.sticky_status;
        OFS_STICKY_LOSS:   st_next.rdata = {{(DATA_W-LOSS_N){1'b0}}, st_reg.sticky_loss};
        OFS_STATUS_MASKS:  st_next.rdata = st_reg.status_masks;
        OFS_LOSS_MASKS:    st_next.rdata = {{(DATA_W-LOSS_N){1'b0}}, st_reg.loss_masks};
        OFS_SOFT_RESET:    st_next.rdata = '0;
        OFS_FREQ_STEP:     st_next.rdata = {{(DATA_W-2){1'b0}}, st_reg.step_strobes};
        OFS_SYNC_PDN_HARD: st_next.rdata = {{(DATA_W-3){1'b0}}, st_reg.sync_strobe,
                                            st_reg.hard_bit, st_reg.low_power};
        OFS_REF_SELECT:    st_next.rdata = {{(DATA_W-SEL_W-1){1'b0}}, st_reg.sel_field,
                                            st_reg.sel_src};
        default:           st_next.rdata = '0;
      endcase
    end
  end

  // single register stage for the whole bank
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg              <= '0;
      st_reg.status_masks <= RST_STATUS_MASKS;
      st_reg.loss_masks   <= RST_LOSS_MASKS;
      st_reg.sel_field    <= RST_REF_SELECT;
      st_reg.seq          <= ST_RUN;
      st_reg.intr_n       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctrl       = st_reg.ctrl;
  assign intr_n     = st_reg.intr_n;
  assign reg_rdata  = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;

  // a read of the live byte returns the calibration level of that cycle
  property p_live_cal;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.addr == OFS_LIVE_STATUS)
      |=> (reg_rdata[BIT_CAL] == $past(live.calibration_in_progress)) && reg_rvalid;
  endproperty
  a_live_cal: assert property (p_live_cal) else $error("live calibration bit wrong");

  // per-input loss reads are the present condition, not latched
  property p_loss_live;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.addr == OFS_INPUT_LOSS)
      |=> reg_rdata == {4'h0, $past(live.per_input_signal_loss)};
  endproperty
  a_loss_live: assert property (p_loss_live) else $error("loss read not live");

  // a live unlock latches its flag on the next edge, even when masked
  property p_unlock_sticks;
    @(posedge ref_clk) disable iff (!rst_n)
      live.pll_unlocked |=> st_reg.sticky_status[BIT_UNLOCK];
  endproperty
  a_unlock_sticks: assert property (p_unlock_sticks) else $error("unlock flag missed");

  // writing zero to one loss flag with no alarm leaves the others alone
  property p_loss_clear_one;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_sticky_l && reg_req.wdata[3:0] == 4'he && live.per_input_signal_loss == 4'h0
       && st_reg.seq == ST_RUN)
      |=> !st_reg.sticky_loss[0] && (st_reg.sticky_loss[3:1] == $past(st_reg.sticky_loss[3:1]));
  endproperty
  a_loss_clear_one: assert property (p_loss_clear_one) else $error("loss clear wrong");

  // interrupt pin matches the unmasked flags
  property p_intr;
    @(posedge ref_clk) disable iff (!rst_n)
      !intr_n == (|(st_reg.sticky_status & ~st_reg.status_masks)
                  || |(st_reg.sticky_loss & ~st_reg.loss_masks));
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt pin wrong");

  // soft reset is a single pulse and brings a divider sync
  property p_soft_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
      (soft_go && !st_next.hard_bit) |=> ctrl.soft_reset && ctrl.divider_sync ##1 !ctrl.soft_reset;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse wrong");

  // writing one to step-up after a quiet cycle gives one step pulse
  property p_step_up;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.addr == OFS_FREQ_STEP && reg_req.wdata[BIT_STEP_UP]
       && !st_reg.step_strobes[BIT_STEP_UP])
      |=> ctrl.frequency_step_up ##1 !ctrl.frequency_step_up;
  endproperty
  a_step_up: assert property (p_step_up) else $error("step up pulse wrong");

  // low power follows the written bit
  property p_low_power;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_ctrl |=> ctrl.low_power_request == $past(reg_req.wdata[0]);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power wrong");

  // while hard reset holds, masks sit at their reset value
  property p_hard_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_reg.seq == ST_HARD) |=> st_reg.status_masks == RST_STATUS_MASKS;
  endproperty
  a_hard_hold: assert property (p_hard_hold) else $error("hard reset hold wrong");

  // selection source follows the control bit
  property p_ref_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> ctrl.ref_select == ($past(st_reg.sel_src) ? $past(st_reg.sel_field)
                                                          : $past(pins_sel));
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");

  // writing one to step-down after a quiet cycle gives one step pulse
  property p_step_down;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.addr == OFS_FREQ_STEP && reg_req.wdata[BIT_STEP_DOWN]
       && !st_reg.step_strobes[BIT_STEP_DOWN])
      |=> ctrl.frequency_step_down ##1 !ctrl.frequency_step_down;
  endproperty
  a_step_down: assert property (p_step_down) else $error("step down pulse wrong");

  // the sync bit gives a divider realign pulse on the next edge
  property p_sync_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_ctrl && reg_req.wdata[BIT_SYNC]) |=> ctrl.divider_sync && st_reg.sync_strobe;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse wrong");

  // setting the hard bit asks for one reload and then holds the reset level
  property p_reload;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_ctrl && reg_req.wdata[BIT_HARD_RST] && !st_reg.hard_bit)
      |=> ctrl.nvm_reload && ctrl.hard_reset ##1 !ctrl.nvm_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("hard reset reload wrong");

  // a masked crystal alarm still latches its flag, only the pin is blocked
  property p_masked_latch;
    @(posedge ref_clk) disable iff (!rst_n)
      (live.crystal_input_signal_loss && st_reg.status_masks[BIT_XTAL])
      |=> st_reg.sticky_status[BIT_XTAL];
  endproperty
  a_masked_latch: assert property (p_masked_latch) else $error("masked flag not latched");

endmodule
`default_nettype wire

// [logic/cgsr_pkg.sv]
`default_nettype none
package cgsr_pkg;

  // widths of the register port and of the fields it carries
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int LOSS_N = 4;
  localparam int SEL_W  = 2;

  // register offsets, page zero
  localparam logic [ADDR_W-1:0] OFS_LIVE_STATUS   = 16'h000c;
  localparam logic [ADDR_W-1:0] OFS_INPUT_LOSS    = 16'h000d;
  localparam logic [ADDR_W-1:0] OFS_STICKY_STATUS = 16'h0011;
  localparam logic [ADDR_W-1:0] OFS_STICKY_LOSS   = 16'h0012;
  localparam logic [ADDR_W-1:0] OFS_STATUS_MASKS  = 16'h0017;
  localparam logic [ADDR_W-1:0] OFS_LOSS_MASKS    = 16'h0018;
  localparam logic [ADDR_W-1:0] OFS_SOFT_RESET    = 16'h001c;
  localparam logic [ADDR_W-1:0] OFS_FREQ_STEP     = 16'h001d;
  localparam logic [ADDR_W-1:0] OFS_SYNC_PDN_HARD = 16'h001e;
  localparam logic [ADDR_W-1:0] OFS_REF_SELECT    = 16'h0021;

  // bit positions in the live, sticky and mask bytes
  localparam int BIT_CAL     = 0;
  localparam int BIT_XTAL    = 1;
  localparam int BIT_REFMISS = 2;
  localparam int BIT_UNLOCK  = 3;
  localparam int BIT_TIMEOUT = 5;
  localparam logic [DATA_W-1:0] STATUS_USED = 8'h2f;  // bit 4 unused

  // control bit positions
  localparam int BIT_SOFT_RST  = 0;
  localparam int BIT_STEP_UP   = 0;
  localparam int BIT_STEP_DOWN = 1;
  localparam int BIT_LOW_POWER = 0;
  localparam int BIT_HARD_RST  = 1;
  localparam int BIT_SYNC      = 2;
  localparam int BIT_SEL_SRC   = 0;
  localparam int SEL_LSB       = 1;

  // reset values, and the select code of the crystal pair
  localparam logic [DATA_W-1:0] RST_STATUS_MASKS = 8'h00;
  localparam logic [LOSS_N-1:0] RST_LOSS_MASKS   = 4'h0;
  localparam logic [SEL_W-1:0]  RST_REF_SELECT   = 2'h0;
  localparam logic [SEL_W-1:0]  SEL_CRYSTAL      = 2'h3;

  // live alarm conditions from the analog side
  typedef struct packed {
    logic              calibration_in_progress;
    logic              crystal_input_signal_loss;
    logic              phase_detector_reference_missing;
    logic              pll_unlocked;
    logic              serial_bus_timeout;
    logic [LOSS_N-1:0] per_input_signal_loss;  // [feedback, two, one, zero]
  } cgsr_status_t;

  // one register access from the serial control port
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cgsr_reg_req_t;

  // controls towards the clock path
  typedef struct packed {
    logic             soft_reset;
    logic             divider_sync;
    logic             frequency_step_up;
    logic             frequency_step_down;
    logic             low_power_request;
    logic             hard_reset;
    logic             nvm_reload;
    logic [SEL_W-1:0] ref_select;
  } cgsr_ctrl_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_SOFT = 3'b010,
    ST_HARD = 3'b100
  } cgsr_seq_t;

endpackage
`default_nettype wire

// [logic/cgsr_sync.sv]
`default_nettype none
module cgsr_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } cgsr_sync_st_t;

  cgsr_sync_st_t st_reg;
  cgsr_sync_st_t st_next;

  // meta is read only by held, never by logic
  always_comb begin
    st_next.meta = d_async;
    st_next.held = st_reg.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.held;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cgsr_pkg::*;

  logic              ref_clk     = 1'b0;
  logic              rst_n       = 1'b0;
  cgsr_reg_req_t     req         = '0;
  cgsr_status_t      st          = '0;
  logic [SEL_W-1:0]  sel         = '0;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  cgsr_ctrl_t        ctrl;
  logic              intr_n;
  int                n_fail      = 0;
  int                check_count = 0;
  int                n_up        = 0;
  cgsr_status_t      s;
  logic [DATA_W-1:0] m;
  logic [LOSS_N-1:0] lm;

  always #12.5 ref_clk = ~ref_clk;

  cgsr_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .status_pins(st), .sel_pins(sel), .ctrl(ctrl), .intr_n(intr_n));

  // counts step-up pulses; a held strobe must give only one
  always @(posedge ref_clk) begin
    if (ctrl.frequency_step_up === 1'b1) n_up++;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask

  // requests launch after an edge and drop at the sampling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input string w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk1("rvalid", 1'b1, rvalid);
    chk(w, e, rdata);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // pins pass two sync stages, so allow four edges before looking
  task automatic set_pins(input cgsr_status_t v);
    @(posedge ref_clk);
    st <= v;
    wait_clk(4);
  endtask

  function automatic logic [DATA_W-1:0] live_of(input cgsr_status_t v);
    live_of = '0;
    live_of[BIT_CAL] = v.calibration_in_progress;
    live_of[BIT_XTAL] = v.crystal_input_signal_loss;
    live_of[BIT_REFMISS] = v.phase_detector_reference_missing;
    live_of[BIT_UNLOCK] = v.pll_unlocked;
    live_of[BIT_TIMEOUT] = v.serial_bus_timeout;
  endfunction

  function automatic logic irq_exp(input cgsr_status_t v, input logic [DATA_W-1:0] sm,
                                   input logic [LOSS_N-1:0] im);
    irq_exp = |(live_of(v) & ~sm) || |(v.per_input_signal_loss & ~im);
  endfunction

  // a hang costs a failure and still reaches the verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(32'he556));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_clk(1);
    // reset values and an unmapped place
    chk1("intr_n", 1'b1, intr_n);
    chk1("ctrl idle", 1'b0, ctrl !== '0);
    rd("masks", OFS_STATUS_MASKS, 8'h00);
    rd("loss masks", OFS_LOSS_MASKS, 8'h00);
    rd("select", OFS_REF_SELECT, 8'h00);
    rd("sticky", OFS_STICKY_STATUS, 8'h00);
    rd("unmapped", 16'h0040, 8'h00);
    $display("test reset done");
    // live bytes follow the pins, per-input loss does not latch
    for (int i = 0; i < 6; i++) begin
      s = cgsr_status_t'($urandom);
      set_pins(s);
      rd("live", OFS_LIVE_STATUS, live_of(s));
      rd("loss live", OFS_INPUT_LOSS, {4'h0, s.per_input_signal_loss});
    end
    set_pins('1);
    set_pins('0);
    rd("loss cleared", OFS_INPUT_LOSS, 8'h00);
    rd("sticky all", OFS_STICKY_STATUS, STATUS_USED);
    rd("sticky loss all", OFS_STICKY_LOSS, 8'h0f);
    wr(OFS_STICKY_STATUS, 8'hf7);
    rd("sticky one cleared", OFS_STICKY_STATUS, 8'h27);
    wr(OFS_STICKY_LOSS, 8'hfe);
    rd("loss one cleared", OFS_STICKY_LOSS, 8'h0e);
    chk1("intr unmasked", 1'b0, intr_n);
    wr(OFS_STATUS_MASKS, 8'hff);
    wr(OFS_LOSS_MASKS, 8'hff);
    wait_clk(1);
    chk1("intr all masked", 1'b1, intr_n);
    rd("masks used bits", OFS_STATUS_MASKS, STATUS_USED);
    rd("loss masks bits", OFS_LOSS_MASKS, 8'h0f);
    $display("test sticky done");
    // random alarms against random masks; flags latch even when masked
    for (int i = 0; i < 8; i++) begin
      s = cgsr_status_t'($urandom);
      m = 8'($urandom) & STATUS_USED;
      lm = 4'($urandom);
      wr(OFS_STICKY_STATUS, 8'h00);
      wr(OFS_STICKY_LOSS, 8'h00);
      wr(OFS_STATUS_MASKS, m);
      wr(OFS_LOSS_MASKS, {4'h0, lm});
      set_pins(s);
      chk1("intr_n", ~irq_exp(s, m, lm), intr_n);
      set_pins('0);
      rd("sticky", OFS_STICKY_STATUS, live_of(s));
      rd("sticky loss", OFS_STICKY_LOSS, {4'h0, s.per_input_signal_loss});
    end
    $display("test interrupt done");
    // soft reset pulses, clears flags, keeps configuration
    wr(OFS_STATUS_MASKS, 8'h2f);
    set_pins('1);
    set_pins('0);
    wr(OFS_SOFT_RESET, 8'h01);
    chk1("soft pulse", 1'b1, ctrl.soft_reset);
    chk1("soft realign", 1'b1, ctrl.divider_sync);
    wait_clk(1);
    chk1("soft ends", 1'b0, ctrl.soft_reset);
    rd("soft bit", OFS_SOFT_RESET, 8'h00);
    rd("flags after soft", OFS_STICKY_STATUS, 8'h00);
    rd("masks kept", OFS_STATUS_MASKS, 8'h2f);
    wr(OFS_SOFT_RESET, 8'h00);
    chk1("soft zero", 1'b0, ctrl.soft_reset);
    $display("test soft reset done");
    // step strobes, one held over two writes gives one pulse
    wr(OFS_FREQ_STEP, 8'h01);
    chk1("step up", 1'b1, ctrl.frequency_step_up);
    wr(OFS_FREQ_STEP, 8'h02);
    chk1("step down", 1'b1, ctrl.frequency_step_down);
    chk1("no up", 1'b0, ctrl.frequency_step_up);
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= OFS_FREQ_STEP;
    req.wdata <= 8'h01;
    repeat (2) @(posedge ref_clk);
    req.wr <= 1'b0;
    wait_clk(3);
    chk("up pulses", 8'h02, 8'(n_up));
    $display("test step done");
    // power down, sync, hard reset
    wr(OFS_SYNC_PDN_HARD, 8'h01);
    wait_clk(3);
    chk1("low power", 1'b1, ctrl.low_power_request);
    wr(OFS_SYNC_PDN_HARD, 8'h05);
    chk1("sync", 1'b1, ctrl.divider_sync);
    wait_clk(1);
    chk1("sync ends", 1'b0, ctrl.divider_sync);
    wr(OFS_SYNC_PDN_HARD, 8'h02);
    chk1("low power off", 1'b0, ctrl.low_power_request);
    chk1("reload", 1'b1, ctrl.nvm_reload);
    wait_clk(3);
    chk1("hard held", 1'b1, ctrl.hard_reset);
    rd("masks in hard", OFS_STATUS_MASKS, 8'h00);
    wr(OFS_STATUS_MASKS, 8'h01);
    rd("masks locked", OFS_STATUS_MASKS, 8'h00);
    wr(OFS_SYNC_PDN_HARD, 8'h00);
    chk1("hard off", 1'b0, ctrl.hard_reset);
    wr(OFS_STATUS_MASKS, 8'h01);
    rd("masks back", OFS_STATUS_MASKS, 8'h01);
    $display("test power and hard done");
    // reference selection from pins, then from the register field
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      sel <= SEL_W'(k);
      wait_clk(4);
      chk("pin select", 8'(k), {6'h00, ctrl.ref_select});
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      sel <= SEL_W'($urandom);
      wr(OFS_REF_SELECT, {5'h00, 2'(k), 1'b1});
      wait_clk(2);
      chk("reg select", 8'(k), {6'h00, ctrl.ref_select});
    end
    $display("test select done");
    // a second reset in mid-run brings back the reset values
    @(posedge ref_clk);
    rst_n <= 1'b0;
    wait_clk(2);
    chk1("intr in reset", 1'b1, intr_n);
    chk("select in reset", 8'h00, {6'h00, ctrl.ref_select});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd("masks after reset", OFS_STATUS_MASKS, 8'h00);
    rd("select after reset", OFS_REF_SELECT, 8'h00);
    $display("test mid reset done");
    finish_test();
  end
endmodule
`default_nettype wire
